// ### hdl/dtps_pkg.sv
/*
 * dtps_pkg: constants shared by the dual timer pin-function selector.
 * Assumes a 32-bit APB register port; offsets are byte addresses.
 */
package dtps_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_OUT_DIS   = 8'h00;  // output_disable_reg
   localparam logic [7:0] OFF_FUNC_CTRL = 8'h04;  // function_control_reg
   localparam logic [7:0] OFF_PWM_MODE  = 8'h08;  // pwm_mode_select_reg
   localparam logic [7:0] OFF_CH0_IO    = 8'h0C;  // chan0 pin io control
   localparam logic [7:0] OFF_CH1_IO    = 8'h10;  // chan1 pin io control
   localparam logic [7:0] OFF_CH0_CTRL  = 8'h14;  // chan0_control_reg
   localparam logic [7:0] OFF_CH1_CTRL  = 8'h18;  // chan1_control_reg
   localparam logic [7:0] OFF_STATUS    = 8'h1C;  // per-pin function, read only

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  RST_OUT_DIS   = 8'hFF;   // all timer outputs disabled
   localparam logic [3:0]  RST_FUNC_CTRL = 4'h8;    // fixed-period pwm bit set
   localparam logic [5:0]  RST_PWM_MODE  = 6'h00;
   localparam logic [15:0] RST_IO        = 16'h0000;
   localparam logic [2:0]  RST_CSS       = 3'h0;

   // ------------------------------------------------------------
   // field layout and encodings
   // ------------------------------------------------------------
   localparam int          NUM_PINS      = 8;
   localparam int          PINS_PER_CH   = 4;
   localparam int          TIMER_WIDTH   = 16;
   localparam int          FC_CMD_LSB    = 0;       // combination_mode_field [1:0]
   localparam int          FC_EXTERNAL_CLOCK_ENABLE_BIT  = 2;       // external_clock_enable
   localparam int          FC_FP_BIT     = 3;       // fixed_period_pwm_bit
   localparam int          IO_STRIDE     = 4;       // one nibble per pin a..d
   localparam int          IO_RSEL_BIT   = 3;       // pin_a_register_select
   localparam int          STAT_CLK_BIT  = 24;      // fast clock in use
   localparam logic [1:0]  CMD_NONE      = 2'b00;
   localparam logic [1:0]  CMD_RSYNC     = 2'b01;
   localparam logic [2:0]  IO_EXT_CLK    = 3'b000;
   localparam logic [2:0]  IO_CMP_TOGGLE = 3'b001;
   localparam logic [2:0]  CSS_FAST_OSC  = 3'b110;

   // pin function, in decode priority order after the port case
   typedef enum logic [2:0] {
      FN_PORT, FN_COMPL, FN_RSYNC, FN_FIXED, FN_PWM, FN_CMP, FN_CAP, FN_EXT
   } dtps_func_type;

endpackage

// ### hdl/dtps_pin_select.sv
/*
 * dtps_pin_select: pin-function selection and operation clock selection
 * for a two-channel timer with four pins per channel.
 * Assumes waveforms come from the counter logic, pins from the port logic.
 */
`timescale 1ns/1ps

// Contract
// [R1] two 16-bit channels, four pins each
// [R2] count source 000b-101b selects system clock
// [R3] count source 110b selects fast oscillator
// [R4] functions chosen per pin, mixable
// [R5] combined modes use both channels jointly
// [R6] compare output conditions, A0 needs register-select
// [R7] capture input conditions, disable bit ignored
// [R8] A0 external clock input conditions
// [R9] complementary pwm on all but A0
// [R10] reset-synchronous pwm on all but A0
// [R11] fixed-period pwm only on A0, B0
// [R12] plain pwm on pins B, C, D
// [R13] software sets port direction to input
// [R14] unmatched pin reverts to port pin
// [R15] fixed decode priority order
module dtps_pin_select #(
   parameter int ADDR_W = 8
) (
   // clock, reset, enable
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire logic              clk_en_i,
   // apb slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // waveforms from the shared counter logic
   input  wire logic [7:0]        cmp_wave_i,
   input  wire logic [7:0]        pwm_wave_i,
   input  wire logic [7:0]        rsync_wave_i,
   input  wire logic [7:0]        compl_wave_i,
   input  wire logic [1:0]        fixed_wave_i,
   // pins
   input  wire logic [7:0]        pin_in_i,
   output logic      [7:0]        pin_out_o,
   output logic      [7:0]        pin_oe_o,
   output logic      [7:0]        port_owned_o,
   // to the counter logic
   output logic      [7:0]        capture_trig_o,
   output logic                   ext_count_clk_o,
   output logic                   clk_sel_fast_o
);

   // ------------------------------------------------------------
   // register file and apb
   // ------------------------------------------------------------
   logic [7:0]  od_q, od_d;
   logic [3:0]  fc_q, fc_d;
   logic [5:0]  pm_q, pm_d;
   logic [15:0] io0_q, io0_d, io1_q, io1_d;
   logic [2:0]  cs0_q, cs0_d, cs1_q, cs1_d;
   logic        pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [31:0] rdat;
   logic        hit;
   logic        fast_d;
   dtps_pkg::dtps_func_type func [dtps_pkg::NUM_PINS];
   logic [23:0] func_flat;

   always_comb begin
      for (int k = 0; k < dtps_pkg::NUM_PINS; k++) begin
         func_flat[k*3 +: 3] = func[k];
      end
   end

   // read mux and address decode; unaligned or unknown offsets miss
   always_comb begin
      rdat = 32'h0000_0000;
      hit  = 1'b1;
      case (paddr_i[7:0])
         dtps_pkg::OFF_OUT_DIS:   rdat[7:0]  = od_q;
         dtps_pkg::OFF_FUNC_CTRL: rdat[3:0]  = fc_q;
         dtps_pkg::OFF_PWM_MODE:  rdat[5:0]  = pm_q;
         dtps_pkg::OFF_CH0_IO:    rdat[15:0] = io0_q;
         dtps_pkg::OFF_CH1_IO:    rdat[15:0] = io1_q;
         dtps_pkg::OFF_CH0_CTRL:  rdat[2:0]  = cs0_q;
         dtps_pkg::OFF_CH1_CTRL:  rdat[2:0]  = cs1_q;
         dtps_pkg::OFF_STATUS: begin
            rdat[23:0] = func_flat;
            rdat[dtps_pkg::STAT_CLK_BIT] = clk_sel_fast_o;
         end
         default: hit = 1'b0;
      endcase
   end

   // one wait state: answer in the second access cycle, write lands there
   always_comb begin
      logic acc;
      logic wr;
      acc       = 1'b0;
      wr        = 1'b0;
      acc       = psel_i & penable_i;
      wr        = acc & pready_q & pwrite_i & hit;
      pready_d  = acc & ~pready_q;
      pslverr_d = acc & ~pready_q & ~hit;
      prdata_d  = (acc & ~pready_q & ~pwrite_i) ? rdat : prdata_q;
      od_d  = od_q;
      fc_d  = fc_q;
      pm_d  = pm_q;
      io0_d = io0_q;
      io1_d = io1_q;
      cs0_d = cs0_q;
      cs1_d = cs1_q;
      if (wr) begin
         case (paddr_i[7:0])
            dtps_pkg::OFF_OUT_DIS:   od_d  = pwdata_i[7:0];
            dtps_pkg::OFF_FUNC_CTRL: fc_d  = pwdata_i[3:0];
            dtps_pkg::OFF_PWM_MODE:  pm_d  = pwdata_i[5:0];
            dtps_pkg::OFF_CH0_IO:    io0_d = pwdata_i[15:0];
            dtps_pkg::OFF_CH1_IO:    io1_d = pwdata_i[15:0];
            dtps_pkg::OFF_CH0_CTRL:  cs0_d = pwdata_i[2:0];
            dtps_pkg::OFF_CH1_CTRL:  cs1_d = pwdata_i[2:0];
            default: ;  // status is read only, write dropped
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         od_q      <= dtps_pkg::RST_OUT_DIS;
         fc_q      <= dtps_pkg::RST_FUNC_CTRL;
         pm_q      <= dtps_pkg::RST_PWM_MODE;
         io0_q     <= dtps_pkg::RST_IO;
         io1_q     <= dtps_pkg::RST_IO;
         cs0_q     <= dtps_pkg::RST_CSS;
         cs1_q     <= dtps_pkg::RST_CSS;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (clk_en_i) begin
         od_q      <= od_d;
         fc_q      <= fc_d;
         pm_q      <= pm_d;
         io0_q     <= io0_d;
         io1_q     <= io1_d;
         cs0_q     <= cs0_d;
         cs1_q     <= cs1_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;
   assign prdata_o  = prdata_q;

   // ------------------------------------------------------------
   // per-pin function decode
   // ------------------------------------------------------------
   logic [1:0] cmd;
   logic       fp, external_clock_enable;
   assign cmd   = fc_q[dtps_pkg::FC_CMD_LSB +: 2];
   assign fp    = fc_q[dtps_pkg::FC_FP_BIT];
   assign external_clock_enable = fc_q[dtps_pkg::FC_EXTERNAL_CLOCK_ENABLE_BIT];

   // one decoder per pin, so each pin picks its own function [R1] [R4]
   for (genvar g = 0; g < dtps_pkg::NUM_PINS; g++) begin : g_pin
      localparam int CH = g / dtps_pkg::PINS_PER_CH;
      localparam int LT = g % dtps_pkg::PINS_PER_CH;
      logic [15:0] iow;
      logic [2:0]  io;
      logic        pmb;
      assign iow = (CH == 0) ? io0_q : io1_q;
      assign io  = iow[LT*dtps_pkg::IO_STRIDE +: 3];
      if (LT == 0) begin : g_a
         assign pmb = 1'b0;  // pin a has no pwm-mode bit
      end else begin : g_bcd
         assign pmb = pm_q[CH*3 + LT - 1];
      end

      // first match wins; the order settles overlapping settings [R15]
      always_comb begin
         logic en;
         logic plain;
         en    = 1'b0;
         plain = 1'b0;
         en    = ~od_q[g];
         plain = fp & (cmd == dtps_pkg::CMD_NONE);
         if (en && cmd[1] && g != 0) begin
            func[g] = dtps_pkg::FN_COMPL;                                   // [R9]
         end else if (en && cmd == dtps_pkg::CMD_RSYNC && g != 0) begin
            func[g] = dtps_pkg::FN_RSYNC;                                   // [R10]
         end else if (en && !fp && cmd == dtps_pkg::CMD_NONE && g < 2) begin
            func[g] = dtps_pkg::FN_FIXED;                                   // [R11]
         end else if (en && plain && LT != 0 && pmb) begin
            func[g] = dtps_pkg::FN_PWM;                                     // [R12]
         end else if (en && plain && !pmb
                      && (io == dtps_pkg::IO_CMP_TOGGLE || io[2:1] == 2'b01)
                      && (g != 0 || iow[dtps_pkg::IO_RSEL_BIT])) begin
            func[g] = dtps_pkg::FN_CMP;                                     // [R6]
         end else if (plain && !pmb && io[2]) begin
            func[g] = dtps_pkg::FN_CAP;                                     // [R7]
         end else if (g == 0 && fp && external_clock_enable && io == dtps_pkg::IO_EXT_CLK) begin
            func[g] = dtps_pkg::FN_EXT;                                     // [R8]
         end else begin
            func[g] = dtps_pkg::FN_PORT;                                    // [R14]
         end
      end
   end

   // ------------------------------------------------------------
   // pin drive, sampling and clock select
   // ------------------------------------------------------------
   logic [7:0] out_d, oe_d, cap_d, own_d;
   logic [7:0] out_q, oe_q, cap_q, own_q;
   logic       ext_d, ext_q, fast_q;

   // combined-mode waveforms are built by both channels' counters [R5]
   always_comb begin
      for (int i = 0; i < dtps_pkg::NUM_PINS; i++) begin
         out_d[i] = 1'b0;
         oe_d[i]  = 1'b1;
         cap_d[i] = 1'b0;
         own_d[i] = 1'b0;
         case (func[i])
            dtps_pkg::FN_COMPL: out_d[i] = compl_wave_i[i];             // [R5]
            dtps_pkg::FN_RSYNC: out_d[i] = rsync_wave_i[i];             // [R5]
            dtps_pkg::FN_FIXED: out_d[i] = fixed_wave_i[i%2];           // [R5]
            dtps_pkg::FN_PWM:   out_d[i] = pwm_wave_i[i];
            dtps_pkg::FN_CMP:   out_d[i] = cmp_wave_i[i];
            // port direction is input here, so the pin level is ours [R13]
            dtps_pkg::FN_CAP: begin
               oe_d[i]  = 1'b0;
               cap_d[i] = pin_in_i[i];
            end
            dtps_pkg::FN_EXT: oe_d[i] = 1'b0;
            default: begin
               // port pin: neither driven nor sampled by the timer [R14]
               oe_d[i]  = 1'b0;
               own_d[i] = 1'b1;
            end
         endcase
      end
      ext_d = (func[0] == dtps_pkg::FN_EXT) ? pin_in_i[0] : 1'b0;        // [R8]
      // either channel on 110b moves the timer to the fast oscillator;
      // mixing sources is a software fault, the fast clock then wins
      fast_d = (cs0_q == dtps_pkg::CSS_FAST_OSC)                         // [R3]
               || (cs1_q == dtps_pkg::CSS_FAST_OSC);                    // [R2]
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_q  <= 8'h00;
         oe_q   <= 8'h00;
         cap_q  <= 8'h00;
         own_q  <= 8'hFF;
         ext_q  <= 1'b0;
         fast_q <= 1'b0;
      end else if (clk_en_i) begin
         out_q  <= out_d;
         oe_q   <= oe_d;
         cap_q  <= cap_d;
         own_q  <= own_d;
         ext_q  <= ext_d;
         fast_q <= fast_d;
      end
   end

   assign pin_out_o       = out_q;
   assign pin_oe_o        = oe_q;
   assign port_owned_o    = own_q;
   assign capture_trig_o  = cap_q;
   assign ext_count_clk_o = ext_q;
   assign clk_sel_fast_o  = fast_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_first_access;
      clk_en_i && psel_i && penable_i && !pready_o;
   endsequence
   sequence s_answer;
      pready_o ##1 (!pready_o || !clk_en_i);
   endsequence

   a_apb_answer_once: assert property (s_first_access |=> s_answer)
      else $error("apb answer not one wait state");

   a_compl_pin_b0: assert property (                                          // [R9]
      clk_en_i && !od_q[1] && cmd[1]
      |=> pin_oe_o[1] && pin_out_o[1] == $past(compl_wave_i[1]))
      else $error("complementary pwm not on pin b0");

   a_rsync_pin_b1: assert property (                                          // [R10]
      clk_en_i && !od_q[5] && cmd == 2'b01
      |=> pin_oe_o[5] && pin_out_o[5] == $past(rsync_wave_i[5]))
      else $error("reset-sync pwm not on pin b1");

   a_fixed_pin_a0: assert property (                                          // [R11]
      clk_en_i && !od_q[0] && !fp && cmd == 2'b00
      |=> pin_oe_o[0] && pin_out_o[0] == $past(fixed_wave_i[0]))
      else $error("fixed-period pwm not on pin a0");

   a_pwm_pin_c0: assert property (                                            // [R12]
      clk_en_i && !od_q[2] && fp && cmd == 2'b00 && pm_q[1]
      |=> pin_oe_o[2] && pin_out_o[2] == $past(pwm_wave_i[2]))
      else $error("plain pwm not on pin c0");

   a_cmp_a0_rsel: assert property (                                           // [R6]
      clk_en_i && !od_q[0] && fp && cmd == 2'b00 && io0_q[2:0] == 3'b011
      |=> pin_oe_o[0] == $past(io0_q[3]))
      else $error("compare output on a0 ignores register select");

   a_capture_d0: assert property (                                            // [R7]
      clk_en_i && fp && cmd == 2'b00 && !pm_q[2] && io0_q[14]
      |=> !pin_oe_o[3] && capture_trig_o[3] == $past(pin_in_i[3]))
      else $error("capture input on d0 not routed");

   a_ext_clock_a0: assert property (                                          // [R8]
      clk_en_i && fp && external_clock_enable && io0_q[2:0] == 3'b000 && od_q[0]
      |=> !pin_oe_o[0] && ext_count_clk_o == $past(pin_in_i[0]))
      else $error("external clock not taken from a0");

   a_port_release: assert property (                                          // [R14]
      clk_en_i && func[6] == dtps_pkg::FN_PORT
      |=> !pin_oe_o[6] && !capture_trig_o[6] && port_owned_o[6])
      else $error("port pin still held by timer");

   a_clock_select: assert property (                                          // [R3]
      clk_en_i
      |=> clk_sel_fast_o == $past(cs0_q == 3'b110 || cs1_q == 3'b110))
      else $error("clock select does not follow 110b");

endmodule

// ### tb/dtps_pad_model.sv
/*
 * dtps_pad_model: package pads plus general-purpose port logic beside the timer.
 * Assumes the bench supplies port direction/value and an outside driver per pad.
 */
`timescale 1ns/1ps

module dtps_pad_model (
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   // timer side
   input  wire logic [7:0] tmr_out_i,
   input  wire logic [7:0] tmr_oe_i,
   // port logic and outside world
   input  wire logic [7:0] port_dir_i,
   input  wire logic [7:0] port_val_i,
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   // resolved pad level
   output logic      [7:0] pad_o
);
   // ----------------------------------------
   // pad resolution
   // ----------------------------------------
   logic [7:0] tgl_q;

   // a floating pad has no pull, so it wanders instead of holding a value
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tgl_q <= 8'h5A;
      end else begin
         tgl_q <= ~tgl_q;
      end
   end

   // timer drive wins, then the port output, then the outside driver
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         if (tmr_oe_i[k]) begin
            pad_o[k] = tmr_out_i[k];
         end else if (port_dir_i[k]) begin
            pad_o[k] = port_val_i[k];
         end else if (ext_en_i[k]) begin
            pad_o[k] = ext_val_i[k];
         end else begin
            pad_o[k] = tgl_q[k];
         end
      end
   end
endmodule

// ### tb/tb.sv
/*
 * tb: self-checking bench for the pin-function selector, driven over APB.
 * Assumes dtps_pkg, dtps_pin_select and dtps_pad_model are compiled first.
 */
`timescale 1ns/1ps

module tb;
   // ----------------------------------------
   // signals and configuration table
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]  od;
      logic [3:0]  fc;
      logic [5:0]  pm;
      logic [15:0] io0;
      logic [15:0] io1;
      logic [2:0]  c0;
      logic [2:0]  c1;
   } dtps_cfg_type;
   logic         clk_sys_i = 1'b0;
   logic         rst_n = 1'b0;
   logic         clk_en = 1'b1;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0000_0000;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic [7:0]   cmp_w = 8'h5A;
   logic [7:0]   pwm_w = 8'h3C;
   logic [7:0]   rs_w = 8'hC3;
   logic [7:0]   cp_w = 8'h96;
   logic [1:0]   fx_w = 2'h2;
   logic [7:0]   port_dir = 8'h00;
   logic [7:0]   ext_en = 8'h00;
   logic [7:0]   ext_val = 8'h69;
   logic [7:0]   pad;
   logic [7:0]   pin_out;
   logic [7:0]   pin_oe;
   logic [7:0]   own;
   logic [7:0]   cap;
   logic         ext;
   logic         fast;
   int           n_fail = 0;
   int           checks_done = 0;
   dtps_cfg_type tbl [9] = '{
      '{8'h00, 4'h2, 6'h00, 16'h0000, 16'h0000, 3'h6, 3'h0},
      '{8'h00, 4'hB, 6'h00, 16'h0000, 16'h0000, 3'h0, 3'h6},
      '{8'h0F, 4'h1, 6'h00, 16'h0000, 16'h0000, 3'h5, 3'h5},
      '{8'h00, 4'h0, 6'h00, 16'h4444, 16'h0000, 3'h7, 3'h0},
      '{8'h00, 4'h8, 6'h38, 16'h4329, 16'h7775, 3'h1, 3'h2},
      '{8'hFF, 4'h8, 6'h01, 16'h1761, 16'h6024, 3'h6, 3'h6},
      '{8'hFF, 4'hF, 6'h00, 16'h0040, 16'h0000, 3'h3, 3'h4},
      '{8'h00, 4'h9, 6'h3F, 16'h4444, 16'h4444, 3'h7, 3'h7},
      '{8'h00, 4'h8, 6'h3F, 16'hCCCC, 16'hCCCC, 3'h6, 3'h7}};

   always #25 clk_sys_i = ~clk_sys_i;

   dtps_pin_select #(.ADDR_W(8)) i_dtps_pin_select (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n), .clk_en_i(clk_en),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .cmp_wave_i(cmp_w), .pwm_wave_i(pwm_w), .rsync_wave_i(rs_w),
      .compl_wave_i(cp_w), .fixed_wave_i(fx_w), .pin_in_i(pad),
      .pin_out_o(pin_out), .pin_oe_o(pin_oe), .port_owned_o(own),
      .capture_trig_o(cap), .ext_count_clk_o(ext), .clk_sel_fast_o(fast));

   dtps_pad_model i_dtps_pad_model (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n), .tmr_out_i(pin_out), .tmr_oe_i(pin_oe),
      .port_dir_i(port_dir), .port_val_i(8'hA5), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pad_o(pad));

   // ----------------------------------------
   // tasks and reference decode
   // ----------------------------------------
   task automatic print_verdict();
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; waits for pready, never assumes a latency
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk_sys_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys_i);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         n_fail++;
         $display("ERROR %0t no pready", $time);
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // expected function code of pin k, in decode priority order
   function automatic logic [2:0] exp_fn(input dtps_cfg_type c, input int k);
      logic       en;
      logic       pw;
      logic       c00;
      logic [3:0] nb;
      en = !c.od[k];
      nb = (k < 4) ? c.io0[4*k +: 4] : c.io1[4*(k-4) +: 4];
      pw = (k % 4 == 0) ? 1'b0 : c.pm[(k < 4) ? k - 1 : k - 2];
      c00 = c.fc[3] && c.fc[1:0] == 2'h0;
      if (k != 0 && en && c.fc[1]) return 3'h1;
      if (k != 0 && en && c.fc[1:0] == 2'h1) return 3'h2;
      if (k < 2 && en && !c.fc[3] && c.fc[1:0] == 2'h0) return 3'h3;
      if (pw && en && c00) return 3'h4;
      if (!pw && en && c00 && nb[2:0] inside {3'h1, 3'h2, 3'h3} && (k != 0 || nb[3]))
         return 3'h5;
      if (!pw && c00 && nb[2]) return 3'h6;
      if (k == 0 && c.fc[3] && c.fc[2] && nb[2:0] == 3'h0) return 3'h7;
      return 3'h0;
   endfunction

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      logic        e;
      logic [2:0]  f;
      logic [23:0] ef;
      logic [7:0]  e_oe;
      logic [7:0]  e_out;
      logic [7:0]  e_own;
      logic [7:0]  e_cap;
      logic        e_ext;
      repeat (4) @(posedge clk_sys_i);
      rst_n <= 1'b1;
      #1;
      chk({own, pin_oe}, 32'h0000_FF00);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0000_0000, r, e);
         chk(r, (i == 0) ? 32'h0000_00FF : (i == 1) ? 32'h0000_0008 : 32'h0000_0000);
      end
      apb(1'b1, dtps_pkg::OFF_PWM_MODE, 32'hFFFF_FFFF, r, e);
      apb(1'b0, dtps_pkg::OFF_PWM_MODE, 32'h0000_0000, r, e);
      chk(r, 32'h0000_003F);
      foreach (tbl[i]) begin
         ef = 24'h00_0000;
         e_oe = 8'h00;
         e_out = 8'h00;
         e_cap = 8'h00;
         cmp_w <= ~cmp_w;
         pwm_w <= ~pwm_w;
         ext_val <= 8'h69 ^ 8'(i);
         for (int k = 0; k < 8; k++) begin
            f = exp_fn(tbl[i], k);
            ef[3*k +: 3] = f;
            e_oe[k] = f inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
            case (f)
               3'h1: e_out[k] = ~cp_w[k];
               3'h2: e_out[k] = rs_w[k];
               3'h3: e_out[k] = fx_w[k];
               // cmp_w and pwm_w flip by the nonblocking writes above
               3'h4: e_out[k] = ~pwm_w[k];
               3'h5: e_out[k] = ~cmp_w[k];
               3'h6: e_cap[k] = 1'((8'h69 ^ 8'(i)) >> k);
               default: e_out[k] = 1'b0;
            endcase
         end
         for (int k = 0; k < 8; k++) e_own[k] = (ef[3*k +: 3] == 3'h0);
         cp_w <= ~cp_w;
         port_dir <= e_own;
         ext_en <= ~e_own & ~e_oe;
         apb(1'b1, dtps_pkg::OFF_OUT_DIS, 32'(tbl[i].od), r, e);
         apb(1'b1, dtps_pkg::OFF_FUNC_CTRL, 32'(tbl[i].fc), r, e);
         apb(1'b1, dtps_pkg::OFF_PWM_MODE, 32'(tbl[i].pm), r, e);
         apb(1'b1, dtps_pkg::OFF_CH0_IO, 32'(tbl[i].io0), r, e);
         apb(1'b1, dtps_pkg::OFF_CH1_IO, 32'(tbl[i].io1), r, e);
         apb(1'b1, dtps_pkg::OFF_CH0_CTRL, 32'(tbl[i].c0), r, e);
         apb(1'b1, dtps_pkg::OFF_CH1_CTRL, 32'(tbl[i].c1), r, e);
         repeat (3) @(posedge clk_sys_i);
         #1;
         chk({8'h00, pin_oe, own, pin_out & e_oe}, {8'h00, e_oe, e_own, e_out});
         chk({cap, 7'h00, ext}, {e_cap, 7'h00, (ef[2:0] == 3'h7) & ext_val[0]});
         e_ext = tbl[i].c0 == dtps_pkg::CSS_FAST_OSC || tbl[i].c1 == dtps_pkg::CSS_FAST_OSC;
         chk({31'h0, fast}, {31'h0, e_ext});
         apb(1'b0, dtps_pkg::OFF_STATUS, 32'h0000_0000, r, e);
         chk(r, {7'h00, e_ext, ef});
      end
      apb(1'b1, dtps_pkg::OFF_STATUS, 32'hFFFF_FFFF, r, e);
      apb(1'b0, dtps_pkg::OFF_STATUS, 32'h0000_0000, r, e);
      chk(r, {7'h00, e_ext, ef});
      apb(1'b0, 8'h20, 32'h0000_0000, r, e);
      chk({r[30:0], e}, 32'h0000_0001);
      apb(1'b1, 8'h02, 32'h0000_0000, r, e);
      chk({31'h0, e}, 32'h0000_0001);
      // a low clock enable freezes the pins; the last table row drives pwm only
      clk_en <= 1'b0;
      pwm_w <= ~pwm_w;
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk({24'h0, pin_out}, {24'h0, e_out});
      @(posedge clk_sys_i);
      clk_en <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk({24'h0, pin_out}, {24'h0, e_out ^ e_oe});
      @(posedge clk_sys_i);
      rst_n <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      chk({own, pin_oe, cap}, 32'h00FF_0000);
      @(posedge clk_sys_i);
      rst_n <= 1'b1;
      apb(1'b0, dtps_pkg::OFF_OUT_DIS, 32'h0000_0000, r, e);
      chk(r, 32'h0000_00FF);
      print_verdict();
   end
endmodule
